//--- design/branch_cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
`include "branch_regs.svh"

module branch_cond_eval (
  // decoded branch
  input  wire branch_pkg::branch_op_t op,
  input  wire logic [7:0]             flags,
  // decision
  output logic                        take
);

  always_comb begin
    take = 1'b0;
    unique case (op)
      branch_pkg::branch_same_or_higher: take = !flags[`FLAG_C];
      branch_pkg::branch_lower: take = flags[`FLAG_C];
      branch_pkg::branch_minus: take = flags[`FLAG_N];
      branch_pkg::branch_plus: take = !flags[`FLAG_N];
      branch_pkg::branch_signed_ge: begin
        take = !(flags[`FLAG_N] ^ flags[`FLAG_V]);
      end
      branch_pkg::branch_signed_lt: begin
        take = flags[`FLAG_N] ^ flags[`FLAG_V];
      end
      branch_pkg::branch_half_carry_set: take = flags[`FLAG_H];
      branch_pkg::branch_half_carry_clear: take = !flags[`FLAG_H];
      branch_pkg::branch_transfer_flag_set: take = flags[`FLAG_T];
      branch_pkg::branch_transfer_flag_clear: begin
        take = !flags[`FLAG_T];
      end
      branch_pkg::branch_overflow_set: take = flags[`FLAG_V];
      default: take = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

//--- design/branch_pkg.sv
package branch_pkg;

  typedef enum logic [3:0] {
    branch_same_or_higher,
    branch_lower,
    branch_minus,
    branch_plus,
    branch_signed_ge,
    branch_signed_lt,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_transfer_flag_set,
    branch_transfer_flag_clear,
    branch_overflow_set
  } branch_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_eval,
    st_jump
  } exec_state_t;

endpackage

//--- design/branch_regs.svh
`ifndef BRANCH_REGS_SVH
`define BRANCH_REGS_SVH

// register byte offsets
`define PC_OFS       8'h00
`define FLAGS_OFS    8'h04
`define ISSUE_OFS    8'h08
`define STATUS_OFS   8'h0C

// status flag bit positions
`define FLAG_C       0
`define FLAG_N       2
`define FLAG_V       3
`define FLAG_H       5
`define FLAG_T       6

// issue register fields
`define ISSUE_OP_LSB 0
`define ISSUE_OP_W   4
`define ISSUE_K_LSB  8

// status register fields
`define STAT_BUSY    0
`define STAT_TAKEN   1

// reset values
`define PC_RST       32'h0000_0000
`define FLAGS_RST    8'h00

// bus responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

//--- design/branch_target_adder.sv
`timescale 1ns/10ps
`default_nettype none

module branch_target_adder #(
  parameter int PCW = 16,
  parameter int KW  = 7
) (
  // operands
  input  wire logic [PCW-1:0] pc,
  input  wire logic [KW-1:0]  k,
  // result
  output logic      [PCW-1:0] target
);

  logic [PCW-1:0] k_ext;

  // signed word displacement
  assign k_ext  = {{(PCW-KW){k[KW-1]}}, k};
  assign target = pc + k_ext + {{(PCW-1){1'b0}}, 1'b1};

endmodule
`default_nettype wire

//--- design/conditional_branch_unit.sv
// Operation
// - carry set: branch on carry jumps to pc plus offset plus one
// - branch on minus jumps only while negative flag is one
// - branch on plus jumps only while negative flag is zero
// - signed greater-or-equal jumps when negative xor overflow is zero
// - signed less-than jumps when negative xor overflow is one
// - half-carry set branch jumps only while half-carry is one
// - half-carry clear branch jumps only while half-carry is zero
// - transfer flag set branch jumps only while transfer flag is one
// - transfer flag clear branch jumps only while transfer flag is zero
// - overflow set branch jumps only while overflow flag is one
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "branch_regs.svh"

module conditional_branch_unit #(
  parameter int PCW = 16,
  parameter int KW  = 7
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // axi write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core view
  output logic [PCW-1:0]   pc_o,
  output logic [7:0]       flags_o,
  output logic             busy_o
);

  logic [7:0]               awaddr_r;
  logic [31:0]              wdata_r;
  logic [3:0]               wstrb_r;
  logic                     aw_held_r;
  logic                     w_held_r;
  logic                     awready_r;
  logic                     wready_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     arready_r;
  logic                     rvalid_r;
  logic [1:0]               rresp_r;
  logic [31:0]              rdata_r;
  logic [PCW-1:0]           pc_r;
  logic [7:0]               flags_r;
  branch_pkg::branch_op_t   op_r;
  logic [KW-1:0]            k_r;
  logic                     taken_r;
  logic                     busy_r;
  branch_pkg::exec_state_t  state_r;
  branch_pkg::exec_state_t  state_nxt;
  logic                     wr_fire;
  logic                     hit_pc;
  logic                     hit_flags;
  logic                     hit_issue;
  logic                     wr_ok;
  logic                     issue_go;
  logic                     take_w;
  logic [PCW-1:0]           target_w;
  logic [31:0]              rd_mux;
  logic [1:0]               rd_resp;
  logic [31:0]              wmerge_pc;
  logic [31:0]              wmerge_flags;

  // merge written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  branch_cond_eval u_cond (
    .op    (op_r),
    .flags (flags_r),
    .take  (take_w)
  );

  branch_target_adder #(
    .PCW (PCW),
    .KW  (KW)
  ) u_adder (
    .pc     (pc_r),
    .k      (k_r),
    .target (target_w)
  );

  // write decode
  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
  assign hit_pc    = (awaddr_r == `PC_OFS);
  assign hit_flags = (awaddr_r == `FLAGS_OFS);
  assign hit_issue = (awaddr_r == `ISSUE_OFS);
  assign issue_go  = wr_fire && hit_issue && (state_r == branch_pkg::st_idle)
                     && wstrb_r[0] && wstrb_r[1];
  assign wr_ok     = (hit_pc && busy_r == 1'b0) || hit_flags || issue_go;
  assign wmerge_pc    = merge({{(32-PCW){1'b0}}, pc_r}, wdata_r, wstrb_r);
  assign wmerge_flags = merge({24'h00_0000, flags_r}, wdata_r, wstrb_r);

  // write address and data capture
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r  <= 8'h00;
    end else if (awvalid && awready_r) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r  <= awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (wvalid && wready_r) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // flags: software only, a branch never writes them
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flags_r <= `FLAGS_RST;
    end else if (wr_fire && hit_flags) begin
      flags_r <= wmerge_flags[7:0];
    end
  end

  // branch latch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      op_r <= branch_pkg::branch_same_or_higher;
      k_r  <= {KW{1'b0}};
    end else if (issue_go) begin
      op_r <= branch_pkg::branch_op_t'(wdata_r[`ISSUE_OP_LSB +: `ISSUE_OP_W]);
      k_r  <= wdata_r[`ISSUE_K_LSB +: KW];
    end
  end

  // execution sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      branch_pkg::st_idle: begin
        if (issue_go) begin
          state_nxt = branch_pkg::st_eval;
        end
      end
      branch_pkg::st_eval: begin
        state_nxt = take_w ? branch_pkg::st_jump : branch_pkg::st_idle;
      end
      branch_pkg::st_jump: begin
        state_nxt = branch_pkg::st_idle;
      end
      default: state_nxt = branch_pkg::st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= branch_pkg::st_idle;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != branch_pkg::st_idle);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      taken_r <= 1'b0;
    end else if (state_r == branch_pkg::st_eval) begin
      taken_r <= take_w;
    end
  end

  // program counter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pc_r <= PCW'(`PC_RST);
    end else if (state_r == branch_pkg::st_jump) begin
      pc_r <= target_w;
    end else if (state_r == branch_pkg::st_eval && !take_w) begin
      pc_r <= pc_r + {{(PCW-1){1'b0}}, 1'b1};
    end else if (wr_fire && hit_pc && !busy_r) begin
      pc_r <= wmerge_pc[PCW-1:0];
    end
  end

  // read mux
  always_comb begin
    rd_mux  = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    unique case (araddr)
      `PC_OFS:     rd_mux = {{(32-PCW){1'b0}}, pc_r};
      `FLAGS_OFS:  rd_mux = {24'h00_0000, flags_r};
      `ISSUE_OFS: begin
        rd_mux[`ISSUE_OP_LSB +: `ISSUE_OP_W] = op_r;
        rd_mux[`ISSUE_K_LSB +: KW]          = k_r;
      end
      `STATUS_OFS: begin
        rd_mux[`STAT_BUSY]  = busy_r;
        rd_mux[`STAT_TAKEN] = taken_r;
      end
      default:     rd_resp = `RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_resp;
    end else if (rvalid_r && rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign pc_o    = pc_r;
  assign flags_o = flags_r;
  assign busy_o  = busy_r;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic in_eval;
  logic [PCW-1:0] k_sext;
  assign in_eval = (state_r == branch_pkg::st_eval);
  assign k_sext  = PCW'($signed(k_r));

  sequence eval_s(branch_pkg::branch_op_t o);
    in_eval && op_r == o;
  endsequence

  sequence jump_s;
    state_r == branch_pkg::st_jump ##1 state_r == branch_pkg::st_idle;
  endsequence

  carry_branch_a: assert property (
    eval_s(branch_pkg::branch_lower) ##0 flags_r[`FLAG_C]
    |=> jump_s ##0 pc_r == $past(pc_r, 2) + k_sext + PCW'(1))
    else $error("carry branch did not jump to target");

  minus_branch_a: assert property (
    eval_s(branch_pkg::branch_minus) |-> take_w == flags_r[`FLAG_N])
    else $error("minus branch decision wrong");

  plus_branch_a: assert property (
    eval_s(branch_pkg::branch_plus) |-> take_w == !flags_r[`FLAG_N])
    else $error("plus branch decision wrong");

  signed_ge_a: assert property (
    eval_s(branch_pkg::branch_signed_ge)
    |-> take_w == !(flags_r[`FLAG_N] ^ flags_r[`FLAG_V]))
    else $error("signed ge decision wrong");

  signed_lt_a: assert property (
    eval_s(branch_pkg::branch_signed_lt)
    |-> take_w == (flags_r[`FLAG_N] ^ flags_r[`FLAG_V]))
    else $error("signed lt decision wrong");

  half_set_a: assert property (
    eval_s(branch_pkg::branch_half_carry_set) |-> take_w == flags_r[`FLAG_H])
    else $error("half carry set decision wrong");

  half_clear_a: assert property (
    eval_s(branch_pkg::branch_half_carry_clear)
    |-> take_w == !flags_r[`FLAG_H])
    else $error("half carry clear decision wrong");

  transfer_set_a: assert property (
    eval_s(branch_pkg::branch_transfer_flag_set)
    |-> take_w == flags_r[`FLAG_T])
    else $error("transfer set decision wrong");

  transfer_clear_a: assert property (
    eval_s(branch_pkg::branch_transfer_flag_clear)
    |-> take_w == !flags_r[`FLAG_T])
    else $error("transfer clear decision wrong");

  overflow_set_a: assert property (
    eval_s(branch_pkg::branch_overflow_set) |-> take_w == flags_r[`FLAG_V])
    else $error("overflow set decision wrong");

  skip_timing_a: assert property (
    in_eval && !take_w
    |=> state_r == branch_pkg::st_idle && pc_r == $past(pc_r) + PCW'(1))
    else $error("untaken branch not one cycle");

  taken_timing_a: assert property (
    in_eval && take_w |=> jump_s ##0 !busy_r)
    else $error("taken branch not two cycles");

  flags_kept_a: assert property (
    state_r != branch_pkg::st_idle && !(wr_fire && hit_flags)
    |=> $stable(flags_r))
    else $error("branch changed a flag");

  signed_offset_a: assert property (
    state_r == branch_pkg::st_jump
    |=> $signed(pc_r - $past(pc_r)) == $signed(k_sext) + 1)
    else $error("offset not signed displacement");

endmodule
`default_nettype wire

//--- tb/conditional_branch_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "branch_regs.svh"

module conditional_branch_unit_tb;
  logic        mclk;
  logic        nrst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] pc_o;
  logic [7:0]  flags_o;
  logic        busy_o;
  int          bad_count;
  int          comparisons;

  conditional_branch_unit #(.PCW(16), .KW(7)) dut (
    .mclk(mclk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pc_o(pc_o), .flags_o(flags_o), .busy_o(busy_o)
  );

  always #20 mclk = ~mclk;

  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("mismatch at %0t: no answer to %s", $time, what);
    final_report();
  endtask

  // one write: address and data offered together, held until taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic done;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    done = 1'b0;
    while (!done) begin
      @(posedge mclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
      if (!done && n > 40) give_up("write");
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int   n;
    logic done;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    done = 1'b0;
    while (!done) begin
      @(posedge mclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
      if (!done && n > 40) give_up("read");
    end
  endtask

  function automatic logic exp_take(input logic [3:0] op,
                                    input logic [7:0] f);
    case (op)
      4'h0: return !f[`FLAG_C];
      4'h1: return f[`FLAG_C];
      4'h2: return f[`FLAG_N];
      4'h3: return !f[`FLAG_N];
      4'h4: return !(f[`FLAG_N] ^ f[`FLAG_V]);
      4'h5: return f[`FLAG_N] ^ f[`FLAG_V];
      4'h6: return f[`FLAG_H];
      4'h7: return !f[`FLAG_H];
      4'h8: return f[`FLAG_T];
      4'h9: return !f[`FLAG_T];
      4'hA: return f[`FLAG_V];
      default: return 1'b0;
    endcase
  endfunction

  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check({16'h0000, pc_o}, 32'h0000_0000, "pc after reset");
    check({24'h000000, flags_o}, 32'h0000_0000, "flags after reset");
    check({31'h0, busy_o}, 32'h0000_0000, "busy after reset");
    axi_read(`PC_OFS, d, r);
    check(d, `PC_RST, "pc register reset");
    axi_read(`FLAGS_OFS, d, r);
    check(d, 32'h0000_0000, "flags register reset");
    $display("test reset done");
  endtask

  // issue one branch and judge target, duration and flags
  task automatic issue_one(input logic [3:0] op, input logic [7:0] f,
                           input logic [15:0] pc0, input logic [6:0] k);
    logic [31:0] d;
    logic [1:0]  r;
    logic        tk;
    logic [15:0] e;
    int          cnt;
    axi_write(`PC_OFS, {16'h0000, pc0}, 4'hF, r);
    axi_write(`FLAGS_OFS, {24'h000000, f}, 4'h1, r);
    axi_write(`ISSUE_OFS, {16'h0000, 1'b0, k, 4'h0, op}, 4'h3, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY}, "issue response");
    cnt = 0;
    while (busy_o === 1'b1 && cnt < 5) begin
      cnt++;
      @(posedge mclk);
    end
    if (busy_o === 1'b1) give_up("branch");
    tk = exp_take(op, f);
    e = tk ? pc0 + {{9{k[6]}}, k} + 16'h0001 : pc0 + 16'h0001;
    check({16'h0000, pc_o}, {16'h0000, e}, "target");
    check(32'(cnt), tk ? 32'h2 : 32'h1, "busy cycles");
    check({24'h000000, flags_o}, {24'h000000, f}, "flags kept");
    axi_read(`STATUS_OFS, d, r);
    check({30'h0, d[1:0]}, {30'h0, tk, 1'b0}, "status taken");
    axi_read(`PC_OFS, d, r);
    check(d, {16'h0000, e}, "pc register");
  endtask

  task automatic test_ops();
    logic [7:0] fl [4];
    fl = '{8'h00, 8'h6D, 8'h04, 8'h08};
    for (int p = 0; p < 4; p++) begin
      for (int op = 0; op < 16; op++) begin
        // odd rows use a negative offset from a low pc to wrap downward
        issue_one(4'(op), fl[p], p[0] ? 16'h0020 : 16'hFFF0,
                  p[0] ? 7'h40 : 7'h3F);
      end
    end
    $display("test ops done");
  endtask

  task automatic test_refuse();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h10, 32'h0000_0000, 4'hF, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
    axi_read(8'h10, d, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped read");
    check(d, 32'h0000_0000, "unmapped read data");
    axi_write(`PC_OFS, 32'h0000_1234, 4'hF, r);
    axi_write(`ISSUE_OFS, 32'h0000_0503, 4'h1, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR}, "partial issue");
    check({31'h0, busy_o}, 32'h0000_0000, "no branch started");
    check({16'h0000, pc_o}, 32'h0000_1234, "pc kept");
    axi_read(`ISSUE_OFS, d, r);
    check(d, 32'h0000_400F, "issue kept");
    axi_write(`STATUS_OFS, 32'h0000_0000, 4'hF, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR}, "status write");
    axi_write(`PC_OFS, 32'h0000_55AA, 4'h1, r);
    check({16'h0000, pc_o}, 32'h0000_12AA, "pc byte strobe");
    $display("test refuse done");
  endtask

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_ops();
    test_refuse();
    final_report();
  end
endmodule

`default_nettype wire
